//--- shared/qrbs_pkg.sv
package qrbs_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int WORD_W = 18;
  localparam int ADDR_W = 4;
  localparam int DEPTH  = 16;
  localparam int BURST  = 4;

  // ----------------------------------------------------------------------
  // Read latency in link clock cycles, per level of the latency select pin
  // ----------------------------------------------------------------------
  localparam int LAT_PIN_HIGH = 2;
  localparam int LAT_PIN_LOW  = 1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [WORD_W-1:0]          qrbs_word_t;
  typedef qrbs_word_t [BURST-1:0]     qrbs_burst_t;
  typedef logic [ADDR_W-1:0]          qrbs_addr_t;

  // Address bus phase: read and write addresses alternate on link rising edges
  typedef enum logic {
    QRBS_PH_RD = 1'b0,
    QRBS_PH_WR = 1'b1
  } qrbs_phase_e;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam qrbs_phase_e PHASE_RST = QRBS_PH_RD;
  localparam qrbs_word_t  WORD_RST  = '0;
  localparam qrbs_addr_t  ADDR_RST  = '0;
  localparam logic        FLAG_RST  = 1'h0;

endpackage : qrbs_pkg

//--- shared/qrbs_mem_if.sv
`timescale 1ns/10ps

interface qrbs_mem_if;
  import qrbs_pkg::*;

  logic        commit;
  qrbs_addr_t  commit_addr;
  qrbs_burst_t commit_data;
  qrbs_addr_t  look_addr;
  qrbs_burst_t look_data;

  modport ctrl  (output commit, commit_addr, commit_data, look_addr, input look_data);
  modport store (input commit, commit_addr, commit_data, look_addr, output look_data);

endinterface : qrbs_mem_if

//--- design/qrbs_sync.sv
`timescale 1ns/10ps

module qrbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_ff  <= d;
    stage_ff <= meta_ff;
  end

  assign q = stage_ff;

endmodule : qrbs_sync

//--- design/qrbs_array.sv
`timescale 1ns/10ps

module qrbs_array
  import qrbs_pkg::*;
(
  input  wire logic link_k,
  qrbs_mem_if.store mem
);

  qrbs_burst_t cell_ff [DEPTH];

  // ----------------------------------------------------------------------
  // Storage: one full burst per address, written in a single edge
  // ----------------------------------------------------------------------
  // No reset: array contents are data, not control state
  always_ff @(posedge link_k) begin
    if (mem.commit) begin
      cell_ff[mem.commit_addr] <= mem.commit_data;
    end
  end

  assign mem.look_data = cell_ff[mem.look_addr];

endmodule : qrbs_array

//--- design/qrbs_sram_port.sv
`timescale 1ns/10ps

// Summary of operation
// - Read port and write port run independently and concurrently.
// - Shared address bus; read and write addresses taken on alternate rising edges.
// - Each address holds a four-word burst moved into or out of the array.
// - Data words move on rising edges of both link clock and complement.
// - Latency pin high: first read word two cycles after address capture.
// - Latency pin low: first read word one cycle after address capture.
// - Separate write data inputs and read data outputs; no turnaround.
// - Independent active-low selects for read port and write port.
// - Inputs captured in input registers; outputs launched from output registers, except the echo pair, which is one gate from two flops.
// - Accepted writes complete by an internal self-timed commit stage.
// - Complementary echo clocks run aligned with read data.
// - Valid output high while read burst words are driven.
// - Reads return newest data, including writes still in the pipeline.

module qrbs_sram_port
  import qrbs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        link_k,
  input  wire logic        link_k_n,
  input  wire logic        dll_off_latency_select,
  input  wire qrbs_addr_t  addr_bus,
  input  wire logic        read_sel_n,
  input  wire logic        write_sel_n,
  input  wire qrbs_word_t  write_data,
  output qrbs_word_t       read_data_rise,
  output qrbs_word_t       read_data_fall,
  output logic             read_data_valid,
  output logic [1:0]       echo_clock_pair,
  output logic             link_ready
);

  // ----------------------------------------------------------------------
  // Reset distribution across the three clocks
  // ----------------------------------------------------------------------
  logic core_run_ff;
  logic link_ready_ff;
  logic k_run;
  logic kn_run;
  logic k_run_core;
  logic lat_two;

  always_ff @(posedge clock) begin
    core_run_ff <= resetn;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      link_ready_ff <= FLAG_RST;
    end else begin
      link_ready_ff <= k_run_core;
    end
  end

  qrbs_sync #(.WIDTH(1)) u_run_k (
    .clk (link_k),
    .d   (core_run_ff),
    .q   (k_run)
  );

  qrbs_sync #(.WIDTH(1)) u_run_kn (
    .clk (link_k_n),
    .d   (core_run_ff),
    .q   (kn_run)
  );

  qrbs_sync #(.WIDTH(1)) u_ready (
    .clk (clock),
    .d   (k_run),
    .q   (k_run_core)
  );

  // Latency pin is static but asynchronous to the link
  qrbs_sync #(.WIDTH(1)) u_lat (
    .clk (link_k),
    .d   (dll_off_latency_select),
    .q   (lat_two)
  );

  // ----------------------------------------------------------------------
  // Input registers and address phase
  // ----------------------------------------------------------------------
  qrbs_phase_e phase_ff;
  qrbs_phase_e nxt_phase;
  qrbs_addr_t  addr_in_ff;
  logic        rd_cap_ff;
  logic        wr_cap_ff;
  qrbs_word_t  din_rise_ff;
  qrbs_word_t  din_fall_ff;
  logic        rd_take;
  logic        wr_take;

  assign nxt_phase = (phase_ff == QRBS_PH_RD) ? QRBS_PH_WR : QRBS_PH_RD;
  assign rd_take   = (phase_ff == QRBS_PH_RD) && !read_sel_n;
  assign wr_take   = (phase_ff == QRBS_PH_WR) && !write_sel_n;

  always_ff @(posedge link_k) begin
    if (!k_run) begin
      phase_ff  <= PHASE_RST;
      rd_cap_ff <= FLAG_RST;
      wr_cap_ff <= FLAG_RST;
    end else begin
      phase_ff  <= nxt_phase;
      rd_cap_ff <= rd_take;
      wr_cap_ff <= wr_take;
    end
  end

  always_ff @(posedge link_k) begin
    addr_in_ff  <= addr_bus;
    din_rise_ff <= write_data;
  end

  // Complement edge capture; read by the rising domain half a cycle later
  always_ff @(posedge link_k_n) begin
    din_fall_ff <= write_data;
  end

  // ----------------------------------------------------------------------
  // Write pipeline: address, low half, full burst, self-timed commit
  // ----------------------------------------------------------------------
  logic        ws1_ff;
  qrbs_addr_t  ws1_addr_ff;
  logic        ws2_ff;
  qrbs_addr_t  ws2_addr_ff;
  qrbs_word_t  ws2_w0_ff;
  qrbs_word_t  ws2_w1_ff;
  logic        pend_ff;
  qrbs_addr_t  pend_addr_ff;
  qrbs_burst_t pend_data_ff;
  qrbs_burst_t nxt_pend_data;

  // Words arrive in ascending order: rise, fall, rise, fall
  assign nxt_pend_data = {din_fall_ff, din_rise_ff, ws2_w1_ff, ws2_w0_ff};

  always_ff @(posedge link_k) begin
    if (!k_run) begin
      ws1_ff  <= FLAG_RST;
      ws2_ff  <= FLAG_RST;
      pend_ff <= FLAG_RST;
    end else begin
      ws1_ff  <= wr_cap_ff;
      ws2_ff  <= ws1_ff;
      pend_ff <= ws2_ff;
    end
  end

  always_ff @(posedge link_k) begin
    ws1_addr_ff  <= addr_in_ff;
    ws2_addr_ff  <= ws1_addr_ff;
    ws2_w0_ff    <= din_rise_ff;
    ws2_w1_ff    <= din_fall_ff;
    pend_addr_ff <= ws2_addr_ff;
    pend_data_ff <= nxt_pend_data;
  end

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  qrbs_mem_if mem ();

  assign mem.commit      = pend_ff;
  assign mem.commit_addr = pend_addr_ff;
  assign mem.commit_data = pend_data_ff;

  qrbs_array u_array (
    .link_k (link_k),
    .mem    (mem.store)
  );

  // ----------------------------------------------------------------------
  // Read pipeline and latency selection
  // ----------------------------------------------------------------------
  logic       rp1_ff;
  qrbs_addr_t rp1_addr_ff;
  logic       half2_ff;
  qrbs_addr_t oaddr_ff;
  logic       launch_req;
  qrbs_addr_t launch_addr;
  logic [1:0] base_idx;
  logic [1:0] next_idx;

  assign launch_req  = lat_two ? rp1_ff : rd_cap_ff;
  assign launch_addr = lat_two ? rp1_addr_ff : addr_in_ff;
  assign base_idx    = launch_req ? 2'h0 : 2'h2;
  assign next_idx    = base_idx | 2'h1;
  assign mem.look_addr = launch_req ? launch_addr : oaddr_ff;

  always_ff @(posedge link_k) begin
    if (!k_run) begin
      rp1_ff <= FLAG_RST;
    end else begin
      rp1_ff <= rd_cap_ff;
    end
    rp1_addr_ff <= addr_in_ff;
  end

  // ----------------------------------------------------------------------
  // Coherency: newest copy of a word wins over the array
  // ----------------------------------------------------------------------
  // Burst still arriving is forwarded straight from the input registers,
  // which costs a compare per stage but keeps reads exact at any spacing.
  function automatic qrbs_word_t pick_newest(
    input logic [1:0] idx,
    input qrbs_addr_t a,
    input qrbs_word_t stored
  );
    qrbs_word_t w;
    w = stored;
    if (pend_ff && (pend_addr_ff == a)) begin
      w = pend_data_ff[idx];
    end
    if (ws2_ff && (ws2_addr_ff == a)) begin
      case (idx)
        2'h0:    w = ws2_w0_ff;
        2'h1:    w = ws2_w1_ff;
        2'h2:    w = din_rise_ff;
        default: w = din_fall_ff;
      endcase
    end
    if (ws1_ff && (ws1_addr_ff == a) && !idx[1]) begin
      w = idx[0] ? din_fall_ff : din_rise_ff;
    end
    return w;
  endfunction : pick_newest

  qrbs_word_t word_rise;
  qrbs_word_t word_fall;

  assign word_rise = pick_newest(base_idx, mem.look_addr, mem.look_data[base_idx]);
  assign word_fall = pick_newest(next_idx, mem.look_addr, mem.look_data[next_idx]);

  // ----------------------------------------------------------------------
  // Output registers, rising domain
  // ----------------------------------------------------------------------
  qrbs_word_t dout_rise_ff;
  qrbs_word_t hold_fall_ff;
  logic       valid_ff;
  logic       echo_r_ff;
  logic       drive_now;

  assign drive_now = launch_req || half2_ff;

  always_ff @(posedge link_k) begin
    if (!k_run) begin
      half2_ff <= FLAG_RST;
      valid_ff <= FLAG_RST;
      oaddr_ff <= ADDR_RST;
    end else begin
      half2_ff <= launch_req;
      valid_ff <= drive_now;
      oaddr_ff <= launch_req ? launch_addr : oaddr_ff;
    end
  end

  always_ff @(posedge link_k) begin
    if (!k_run) begin
      dout_rise_ff <= WORD_RST;
      hold_fall_ff <= WORD_RST;
    end else if (drive_now) begin
      dout_rise_ff <= word_rise;
      hold_fall_ff <= word_fall;
    end
  end

  always_ff @(posedge link_k) begin
    if (!k_run) begin
      echo_r_ff <= FLAG_RST;
    end else begin
      echo_r_ff <= !echo_r_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers, complement domain
  // ----------------------------------------------------------------------
  qrbs_word_t dout_fall_ff;
  logic       echo_f_ff;

  always_ff @(posedge link_k_n) begin
    if (!kn_run) begin
      dout_fall_ff <= WORD_RST;
      echo_f_ff    <= FLAG_RST;
    end else begin
      dout_fall_ff <= hold_fall_ff;
      echo_f_ff    <= echo_r_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // Separate read outputs and write inputs: never a turnaround cycle
  assign read_data_rise  = dout_rise_ff;
  assign read_data_fall  = dout_fall_ff;
  assign read_data_valid = valid_ff;
  assign link_ready      = link_ready_ff;

  // Echo high after each link rise, low after each complement rise;
  // one gate from two launch flops keeps it in step with the data flops.
  assign echo_clock_pair[0] = echo_r_ff ^ echo_f_ff;
  assign echo_clock_pair[1] = !(echo_r_ff ^ echo_f_ff);

endmodule : qrbs_sram_port

//--- sim/qrbs_sram_port_asserts.sv
`timescale 1ns/10ps

module qrbs_sram_port_asserts
  import qrbs_pkg::*;
(
  input wire logic       link_k,
  input wire logic       link_k_n,
  input wire logic       link_ready,
  input wire logic       dll_off_latency_select,
  input wire logic       read_sel_n,
  input wire logic       write_sel_n,
  input wire qrbs_word_t read_data_rise,
  input wire qrbs_word_t read_data_fall,
  input wire logic       read_data_valid,
  input wire logic [1:0] echo_clock_pair
);
  // ----------------------------------------------------------------
  // Link checks; link_ready stands in for the hidden link reset
  // ----------------------------------------------------------------
  chk_echo_at_rise: assert property (@(posedge link_k) disable iff (!link_ready)
    echo_clock_pair == 2'h2) else $error("echo pair wrong at link rise");
  chk_echo_at_fall: assert property (@(posedge link_k_n) disable iff (!link_ready)
    echo_clock_pair == 2'h1) else $error("echo pair wrong at complement rise");
  chk_latency_two: assert property (@(posedge link_k) disable iff (!link_ready)
    $rose(read_data_valid) && dll_off_latency_select |-> !$past(read_sel_n, 3))
    else $error("valid rose without a read three edges back");
  chk_latency_one: assert property (@(posedge link_k) disable iff (!link_ready)
    $rose(read_data_valid) && !dll_off_latency_select |-> !$past(read_sel_n, 2))
    else $error("valid rose without a read two edges back");
  chk_no_read_idle: assert property (@(posedge link_k) disable iff (!link_ready)
    read_sel_n [*4] |=> !read_data_valid) else $error("valid without any read");
  chk_burst_pair: assert property (@(posedge link_k) disable iff (!link_ready)
    $rose(read_data_valid) |=> read_data_valid) else $error("burst shorter than two cycles");
  chk_rise_hold: assert property (@(posedge link_k) disable iff (!link_ready)
    !read_data_valid |-> $stable(read_data_rise)) else $error("rise word moved while idle");
  chk_fall_hold: assert property (@(posedge link_k_n) disable iff (!link_ready)
    !read_data_valid && !$past(read_data_valid) |-> $stable(read_data_fall))
    else $error("fall word moved while idle");
  // Main scenarios reached
  cov_latency_one: cover property (@(posedge link_k)
    $rose(read_data_valid) && !dll_off_latency_select);
  cov_back_to_back: cover property (@(posedge link_k) read_data_valid [*4]);
  cov_concurrent: cover property (@(posedge link_k) read_data_valid && !write_sel_n);
endmodule : qrbs_sram_port_asserts

bind qrbs_sram_port qrbs_sram_port_asserts u_chk (
  .link_k, .link_k_n, .link_ready, .dll_off_latency_select, .read_sel_n, .write_sel_n,
  .read_data_rise, .read_data_fall, .read_data_valid, .echo_clock_pair
);

//--- sim/qrbs_ctrl_model.sv
`timescale 1ns/10ps

module qrbs_ctrl_model
  import qrbs_pkg::*;
(
  input  wire logic link_k,
  input  wire logic link_k_n,
  output qrbs_addr_t addr_bus,
  output logic       read_sel_n,
  output logic       write_sel_n,
  output qrbs_word_t write_data
);
  initial begin
    addr_bus = ADDR_RST;
    read_sel_n = 1'h1;
    write_sel_n = 1'h1;
    write_data = WORD_RST;
  end

  // ----------------------------------------------------------------
  // One read phase then one write phase, entered after a write edge
  // ----------------------------------------------------------------
  task automatic slot(input logic re, input qrbs_addr_t ra, input logic we,
                      input qrbs_addr_t wa, input qrbs_burst_t d);
    addr_bus <= ra;
    read_sel_n <= !re;
    write_sel_n <= 1'h1;
    @(posedge link_k);
    addr_bus <= wa;
    read_sel_n <= 1'h1;
    write_sel_n <= !we;
    // Words overlap the next slot; garbage goes out even when deselected
    fork
      begin
        @(posedge link_k);
        @(posedge link_k_n) write_data <= d[0];
        @(posedge link_k) write_data <= d[1];
        @(posedge link_k_n) write_data <= d[2];
        @(posedge link_k) write_data <= d[3];
      end
    join_none
    @(posedge link_k);
  endtask : slot

  // Read select low on two edges: exactly one of them is a read phase
  task automatic probe();
    read_sel_n <= 1'h0;
    repeat (2) @(posedge link_k);
    read_sel_n <= 1'h1;
  endtask : probe
endmodule : qrbs_ctrl_model

//--- sim/qrbs_sram_port_tb.sv
`timescale 1ns/10ps

module qrbs_sram_port_tb;
  import qrbs_pkg::*;

  // ----------------------------------------------------------------
  // Pins and bookkeeping
  // ----------------------------------------------------------------
  logic        clock = 1'h0;
  logic        link_k = 1'h0;
  logic        resetn = 1'h0;
  logic        dll_off_latency_select = 1'h1;
  wire logic   link_k_n = ~link_k;
  qrbs_addr_t  addr_bus;
  logic        read_sel_n;
  logic        write_sel_n;
  qrbs_word_t  write_data;
  qrbs_word_t  read_data_rise;
  qrbs_word_t  read_data_fall;
  logic        read_data_valid;
  logic [1:0]  echo_clock_pair;
  logic        link_ready;
  int          err_total = 0;
  int          samples_checked = 0;
  int          kcnt = 0;
  int          vcnt = 0;
  int          v_edge = 0;
  int          lat = LAT_PIN_HIGH;
  int          rpar = 0;
  logic        pend = 1'h0;
  logic        probing = 1'h0;
  qrbs_addr_t  last_wa = ADDR_RST;
  qrbs_burst_t mem [DEPTH];
  qrbs_word_t  exp_q [$];
  int          cap_q [$];

  initial forever #20 clock = ~clock;
  initial begin
    #7;
    forever #24 link_k = ~link_k;
  end

  qrbs_sram_port dut (
    .clock, .resetn, .link_k, .link_k_n, .dll_off_latency_select, .addr_bus, .read_sel_n,
    .write_sel_n, .write_data, .read_data_rise, .read_data_fall, .read_data_valid,
    .echo_clock_pair, .link_ready
  );
  qrbs_ctrl_model ctl (.link_k, .link_k_n, .addr_bus, .read_sel_n, .write_sel_n, .write_data);

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  function automatic int due(input int cap);
    return cap + lat;
  endfunction : due

  // kcnt moves by NBA so procedures woken by the same edge all see one value
  always @(posedge link_k) begin
    kcnt <= kcnt + 1;
    if (pend) begin
      pend <= 1'h0;
      check(read_data_fall, exp_q.pop_front());
    end
  end

  always @(posedge link_k_n) begin
    if (read_data_valid === 1'h1) begin
      vcnt <= vcnt + 1;
      if (probing) begin
        if (vcnt == 0) v_edge <= kcnt;
      end else begin
        if (vcnt % 2 == 0) check(kcnt, due(cap_q.pop_front()));
        check(read_data_rise, exp_q.pop_front());
        pend <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic go(input logic re, input qrbs_addr_t ra, input logic we, input qrbs_addr_t wa);
    qrbs_burst_t d;
    for (int b = 0; b < BURST; b++) d[b] = qrbs_word_t'($urandom);
    if (re) begin
      cap_q.push_back(kcnt + 2);
      for (int b = 0; b < BURST; b++) exp_q.push_back(mem[ra][b]);
    end
    if (we) begin
      mem[wa] = d;
      last_wa = wa;
    end
    ctl.slot(re, ra, we, wa, d);
  endtask : go

  task automatic run(input int n);
    qrbs_addr_t ra;
    qrbs_addr_t wa;
    for (int i = 0; i < n; i++) begin
      ra = (i % 3 == 0) ? last_wa : qrbs_addr_t'($urandom);
      wa = qrbs_addr_t'($urandom);
      if (wa == ra) wa = qrbs_addr_t'(ra + 1);
      go($urandom % 4 != 0, ra, $urandom % 4 != 0, wa);
    end
  endtask : run

  task automatic drain();
    repeat (4) go(1'h0, ADDR_RST, 1'h0, ADDR_RST);
    check(exp_q.size() + cap_q.size(), 0);
  endtask : drain

  task automatic align();
    @(posedge link_k);
    for (int i = 0; i < 2 && (kcnt + 2) % 2 != rpar; i++) @(posedge link_k);
  endtask : align

  initial begin
    void'($urandom(4));
    repeat (6) @(posedge clock);
    resetn <= 1'h1;
    for (int i = 0; i < 40 && link_ready !== 1'h1; i++) @(posedge clock);
    check(link_ready, 1'h1);
    if (link_ready !== 1'h1) give_verdict();
    @(posedge link_k);
    probing = 1'h1;
    ctl.probe();
    repeat (6) @(posedge link_k);
    probing = 1'h0;
    check(vcnt, 2);
    rpar = (v_edge - LAT_PIN_HIGH) % 2;
    align();
    for (int a = 0; a < DEPTH; a++) go(1'h0, ADDR_RST, 1'h1, qrbs_addr_t'(a));
    run(60);
    drain();
    @(posedge clock);
    dll_off_latency_select <= 1'h0;
    lat = LAT_PIN_LOW;
    align();
    drain();
    run(60);
    drain();
    give_verdict();
  end

  initial begin
    #1000000;
    check(1'h0, 1'h1);
    give_verdict();
  end
endmodule : qrbs_sram_port_tb
